// >>> hw/exec_subset_pkg.sv
// constants for the instruction execute subset
// Overview of operation
// RL1 - load literal copies 8-bit immediate into accumulator, flags untouched
// RL2 - config load copies accumulator into config register, no flags
// RL3 - return loads immediate to accumulator, pc from stack top, two cycles
// RL4 - power-down clears watchdog counter to zero and its prescaler
// RL5 - power-down sets time-out flag high, power-down flag low, wake kept
// RL6 - power-down then halts the core in sleep, oscillator stopped
// RL7 - rotate left file register through carry, only carry changes
// RL8 - rotate destination bit 0 to accumulator, 1 back to file
// RL9 - subtract accumulator from file by two's complement, sets C, DC, Z
// RL10 - subtract destination bit 0 to accumulator, 1 back to file
// RL11 - no-operation only advances program counter in one cycle
package exec_subset_pkg;
    localparam int IW = 12;
    localparam int DW = 8;
    localparam int FW = 5;
    localparam int PCW_DEF = 9;

    // full-word opcodes
    localparam logic [IW-1:0] OP_NOP = 12'h000;
    localparam logic [IW-1:0] OP_CONFIG = 12'h002;
    localparam logic [IW-1:0] OP_SLEEP = 12'h003;
    // literal opcodes, bits 11:8
    localparam logic [3:0] OPL_LOAD = 4'hC;
    localparam logic [3:0] OPL_RETURN = 4'h8;
    // file opcodes, bits 11:6
    localparam logic [5:0] OPF_ROTATE = 6'h0D;
    localparam logic [5:0] OPF_SUBTRACT = 6'h02;
    // field positions
    localparam int DEST_BIT = 5;
    localparam int LIT_MSB = 7;
    localparam int FADDR_MSB = 4;

    // reset values
    localparam logic [DW-1:0] ACC_RST = 8'h00;
    localparam logic [DW-1:0] CONFIG_RST = 8'hFF;
    localparam logic [DW-1:0] WDT_CLEAR = 8'h00;
    localparam logic [DW-1:0] PRESCALE_CLEAR = 8'h00;
    localparam logic FLAG_N_RST = 1'b1;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_FLUSH = 2'b01,
        ST_SLEEP = 2'b10
    } core_state_t;
endpackage : exec_subset_pkg

// >>> hw/exec_subset.sv
// execute logic for the literal, config, return, sleep, rotate, subtract set
`timescale 1ns/1ps
module exec_subset
    import exec_subset_pkg::*;
#(
    parameter int PCW = PCW_DEF
) (
    input wire logic mclk, // core clock, 200 MHz
    input wire logic rstn, // async reset
    input wire logic clk_en, // freezes all state while low
    output logic [PCW-1:0] prog_addr, // fetch address
    input wire logic [IW-1:0] prog_data, // instruction word
    input wire logic [PCW-1:0] stack_top_entry, // return address
    output logic stack_pop, // pop request
    output logic [FW-1:0] file_addr, // file read address
    input wire logic [DW-1:0] file_rdata, // file read data
    output logic [FW-1:0] file_waddr, // file write address
    output logic [DW-1:0] file_wdata, // file write data
    output logic file_we, // file write strobe
    input wire logic wdt_tick, // watchdog time base
    input wire logic wake_pin, // async wake request
    output logic [DW-1:0] acc, // accumulator
    output logic [DW-1:0] config_reg, // configuration register
    output logic carry_flag, // carry
    output logic digit_carry_flag, // nibble carry
    output logic zero_flag, // zero result
    output logic timeout_flag_n, // time-out status
    output logic powerdown_flag_n, // power-down status
    output logic [DW-1:0] watchdog_counter, // watchdog count
    output logic [DW-1:0] wdt_prescaler, // watchdog prescale
    output logic sleeping, // core halted
    output logic osc_run // oscillator enable
);

    ////////////////////////////////////////////////////////////////////////

    core_state_t state;
    core_state_t next_state;
    logic [PCW-1:0] pc;
    logic wake_meta;
    logic wake_sync;

    wire exec_go = clk_en && (state == ST_EXEC);
    wire [IW-1:0] instr = prog_data;
    wire is_nop = instr == OP_NOP;
    wire is_config = instr == OP_CONFIG;
    wire is_sleep = instr == OP_SLEEP;
    wire is_load = instr[11:8] == OPL_LOAD;
    wire is_return = instr[11:8] == OPL_RETURN;
    wire is_rotate = instr[11:6] == OPF_ROTATE;
    wire is_sub = instr[11:6] == OPF_SUBTRACT;
    wire to_file = instr[DEST_BIT];
    wire [DW-1:0] literal = instr[LIT_MSB:0];

    assign prog_addr = pc;
    assign file_addr = instr[FADDR_MSB:0];
    assign stack_pop = exec_go && is_return;
    assign sleeping = state == ST_SLEEP;
    assign osc_run = !sleeping; // [RL6]

    // pending write forwarded so back-to-back file ops see fresh data
    wire fwd_hit = file_we && (file_waddr == file_addr);
    wire [DW-1:0] fval = fwd_hit ? file_wdata : file_rdata;

    ////////////////////////////////////////////////////////////////////////
    // datapath results

    wire [DW-1:0] rot_res = {fval[DW-2:0], carry_flag}; // [RL7]
    wire rot_carry = fval[DW-1]; // [RL7]

    wire [DW:0] sub_sum = {1'b0, fval} + {1'b0, ~acc} + 9'h001; // [RL9]
    wire [4:0] sub_low = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    wire [DW-1:0] sub_res = sub_sum[DW-1:0];
    wire sub_carry = sub_sum[DW]; // [RL9]
    wire sub_dcarry = sub_low[4]; // [RL9]
    wire sub_zero = sub_res == 8'h00; // [RL9]

    wire file_op = is_rotate || is_sub;
    wire [DW-1:0] file_res = is_rotate ? rot_res : sub_res;
    wire write_acc = is_load || is_return || (file_op && !to_file);
    wire [DW-1:0] next_acc = file_op ? file_res : literal; // [RL1] [RL3]
    wire write_file = exec_go && file_op && to_file; // [RL8] [RL10]

    ////////////////////////////////////////////////////////////////////////
    // sequencing

    always_comb begin
        next_state = state;
        unique case (state)
            ST_EXEC: begin
                if (is_return) begin
                    next_state = ST_FLUSH; // [RL3]
                end else if (is_sleep) begin
                    next_state = ST_SLEEP; // [RL6]
                end
            end
            ST_FLUSH: begin
                next_state = ST_EXEC;
            end
            ST_SLEEP: begin
                if (wake_sync) begin
                    next_state = ST_EXEC;
                end
            end
            default: begin
                next_state = ST_EXEC;
            end
        endcase
    end

    wire [PCW-1:0] pc_inc = pc + PCW'(1);
    wire [PCW-1:0] next_pc = is_return ? stack_top_entry : pc_inc; // [RL3]

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_EXEC;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pc <= '0;
        end else if (exec_go) begin
            pc <= next_pc; // [RL11]
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else if (clk_en) begin
            wake_meta <= wake_pin;
            wake_sync <= wake_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // architectural registers

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            acc <= ACC_RST;
        end else if (exec_go && write_acc) begin
            acc <= next_acc; // [RL1] [RL3] [RL8] [RL10]
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            config_reg <= CONFIG_RST;
        end else if (exec_go && is_config) begin
            config_reg <= acc; // [RL2]
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            carry_flag <= 1'b0;
        end else if (exec_go && is_rotate) begin
            carry_flag <= rot_carry; // [RL7]
        end else if (exec_go && is_sub) begin
            carry_flag <= sub_carry; // [RL9]
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            digit_carry_flag <= 1'b0;
            zero_flag <= 1'b0;
        end else if (exec_go && is_sub) begin
            digit_carry_flag <= sub_dcarry; // [RL9]
            zero_flag <= sub_zero; // [RL9]
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            file_we <= 1'b0;
            file_waddr <= '0;
            file_wdata <= '0;
        end else if (clk_en) begin
            file_we <= write_file; // [RL8] [RL10]
            if (write_file) begin
                file_waddr <= file_addr;
                file_wdata <= file_res;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            timeout_flag_n <= FLAG_N_RST;
            powerdown_flag_n <= FLAG_N_RST;
        end else if (exec_go && is_sleep) begin
            timeout_flag_n <= 1'b1; // [RL5]
            powerdown_flag_n <= 1'b0; // [RL5]
        end
    end

    // watchdog keeps counting in sleep; the prescaler wrap steps it
    wire [DW-1:0] pre_inc = wdt_prescaler + 8'h01;
    wire pre_wrap = wdt_tick && (wdt_prescaler == 8'hFF);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wdt_prescaler <= PRESCALE_CLEAR;
            watchdog_counter <= WDT_CLEAR;
        end else if (exec_go && is_sleep) begin
            wdt_prescaler <= PRESCALE_CLEAR; // [RL4]
            watchdog_counter <= WDT_CLEAR; // [RL4]
        end else if (clk_en && wdt_tick) begin
            wdt_prescaler <= pre_inc;
            if (pre_wrap) begin
                watchdog_counter <= watchdog_counter + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence ret_taken_s;
        exec_go && is_return;
    endsequence

    sequence ret_flush_s;
        state == ST_FLUSH && stack_pop == 1'b0;
    endsequence

    sequence sleep_taken_s;
        exec_go && is_sleep;
    endsequence

    load_literal_a: assert property ( // [RL1]
        exec_go && is_load |=> acc == $past(literal)
            && $stable(carry_flag) && $stable(zero_flag)
            && $stable(digit_carry_flag))
        else $error("literal load wrong");

    config_load_a: assert property ( // [RL2]
        exec_go && is_config |=> config_reg == $past(acc)
            && $stable(acc) && $stable(carry_flag))
        else $error("config load wrong");

    return_seq_a: assert property ( // [RL3]
        ret_taken_s |=> ret_flush_s
            and (pc == $past(stack_top_entry)
            && acc == $past(literal) && $stable(zero_flag)))
        else $error("return sequence wrong");

    sleep_wdt_a: assert property ( // [RL4]
        sleep_taken_s |=> watchdog_counter == 8'h00
            && wdt_prescaler == 8'h00)
        else $error("watchdog not cleared by sleep");

    sleep_flags_a: assert property ( // [RL5]
        sleep_taken_s |=> timeout_flag_n && !powerdown_flag_n)
        else $error("sleep status flags wrong");

    sleep_halt_a: assert property ( // [RL6]
        sleep_taken_s |=> sleeping && !osc_run
            && pc == $past(pc_inc))
        else $error("sleep did not halt");

    rotate_acc_a: assert property ( // [RL7]
        exec_go && is_rotate && !to_file |=>
            acc == {$past(fval[6:0]), $past(carry_flag)}
            && carry_flag == $past(fval[7]) && $stable(zero_flag))
        else $error("rotate result wrong");

    rotate_file_a: assert property ( // [RL8]
        exec_go && is_rotate && to_file |=> file_we
            && file_waddr == $past(file_addr)
            && file_wdata == $past(rot_res) && $stable(acc))
        else $error("rotate destination wrong");

    subtract_a: assert property ( // [RL9]
        exec_go && is_sub |=>
            carry_flag == ($past(fval) >= $past(acc))
            && zero_flag == ($past(fval) == $past(acc)))
        else $error("subtract flags wrong");

    subtract_dest_a: assert property ( // [RL10]
        exec_go && is_sub && !to_file |=>
            acc == 8'($past(fval) - $past(acc)) && !file_we)
        else $error("subtract destination wrong");

    no_effect_a: assert property ( // [RL11]
        exec_go && is_nop |=> pc == $past(pc_inc) && $stable(acc)
            && !file_we && state == ST_EXEC && $stable(carry_flag))
        else $error("no-op changed state");

endmodule : exec_subset

// >>> testbench/prog_mem_model.sv
// program memory and file register stand-in for the execute subset
`timescale 1ns/1ps
module prog_mem_model
    import exec_subset_pkg::*;
#(
    parameter int PCW = PCW_DEF
) (
    input wire logic mclk, // core clock
    input wire logic clk_en, // write qualifier
    input wire logic [PCW-1:0] prog_addr, // fetch address
    output logic [IW-1:0] prog_data, // instruction word
    input wire logic [FW-1:0] file_addr, // read address
    output logic [DW-1:0] file_rdata, // read data
    input wire logic [FW-1:0] file_waddr, // write address
    input wire logic [DW-1:0] file_wdata, // write data
    input wire logic file_we // write strobe
);
    logic [IW-1:0] rom [2**PCW];
    logic [DW-1:0] regs [2**FW];
    assign prog_data = rom[prog_addr];
    assign file_rdata = regs[file_addr];
    always @(posedge mclk) begin
        if (file_we && clk_en) begin
            regs[file_waddr] <= file_wdata;
        end
    end
endmodule : prog_mem_model

// >>> testbench/tb_cpu_instruction_execute_subset.sv
// random program run against a reference model, then sleep and wake
`timescale 1ns/1ps
module tb_cpu_instruction_execute_subset
    import exec_subset_pkg::*;
;
    logic mclk, rstn, clk_en, wdt_tick, wake_pin, stack_pop, file_we;
    logic carry_flag, digit_carry_flag, zero_flag, sleeping, osc_run;
    logic timeout_flag_n, powerdown_flag_n;
    logic [8:0] prog_addr, stack_top_entry, m_pc;
    logic [IW-1:0] prog_data;
    logic [FW-1:0] file_addr, file_waddr, m_wa;
    logic [DW-1:0] file_rdata, file_wdata, acc, config_reg;
    logic [DW-1:0] watchdog_counter, wdt_prescaler;
    logic [DW-1:0] m_acc, m_cfg, m_wdt, m_pre, m_wd;
    logic [DW-1:0] m_f [32];
    logic m_c, m_dc, m_z, m_to, m_pd, m_we, m_flush, m_sleep;
    int n_fail = 0, checked = 0, cycles = 0;

    exec_subset u_dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .stack_top_entry(stack_top_entry), .stack_pop(stack_pop),
        .file_addr(file_addr), .file_rdata(file_rdata),
        .file_waddr(file_waddr), .file_wdata(file_wdata),
        .file_we(file_we), .wdt_tick(wdt_tick), .wake_pin(wake_pin),
        .acc(acc), .config_reg(config_reg), .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
        .timeout_flag_n(timeout_flag_n),
        .powerdown_flag_n(powerdown_flag_n),
        .watchdog_counter(watchdog_counter),
        .wdt_prescaler(wdt_prescaler), .sleeping(sleeping),
        .osc_run(osc_run));
    prog_mem_model u_mem (.mclk(mclk), .clk_en(clk_en),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .file_addr(file_addr), .file_rdata(file_rdata),
        .file_waddr(file_waddr), .file_wdata(file_wdata),
        .file_we(file_we));

    ////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    ////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] rand_op();
        case ($urandom_range(6))
            0: return OP_NOP;
            1: return OP_CONFIG;
            2: return {OPL_LOAD, 8'($urandom)};
            3: return {OPL_RETURN, 8'($urandom)};
            4: return {OPF_ROTATE, 6'($urandom)};
            5: return {OPF_SUBTRACT, 6'($urandom)};
            default: return 12'h0FF;
        endcase
    endfunction : rand_op

    task automatic compare_all();
        chk(16'(prog_addr), 16'(m_pc));
        chk(16'(acc), 16'(m_acc));
        chk(16'(config_reg), 16'(m_cfg));
        chk(16'({carry_flag, digit_carry_flag, zero_flag}),
            16'({m_c, m_dc, m_z}));
        chk(16'({timeout_flag_n, powerdown_flag_n}),
            16'({m_to, m_pd}));
        chk(16'({stack_pop, file_addr}), 16'({clk_en && !m_sleep && !m_flush
            && u_mem.rom[m_pc][11:8] == OPL_RETURN,
            u_mem.rom[m_pc][4:0]}));
        chk({watchdog_counter, wdt_prescaler}, {m_wdt, m_pre});
        chk(16'({sleeping, osc_run}), 16'({m_sleep, !m_sleep}));
        chk(16'(file_we), 16'(m_we));
        if (m_we) begin
            chk({3'h0, file_waddr, file_wdata}, {3'h0, m_wa, m_wd});
        end
    endtask : compare_all

    task automatic step();
        logic [11:0] op;
        logic [7:0] f;
        logic [7:0] r;
        logic [8:0] np;
        if (!clk_en) return;
        if (wdt_tick) begin
            m_pre++;
            if (m_pre == 8'h00) m_wdt++;
        end
        if (m_sleep) return;
        m_we = 1'b0;
        if (m_flush) begin
            m_flush = 1'b0;
            return;
        end
        op = u_mem.rom[m_pc];
        f = m_f[op[4:0]];
        np = m_pc + 9'h001;
        if (op[11:8] == OPL_LOAD) m_acc = op[7:0];
        else if (op[11:8] == OPL_RETURN) begin
            m_acc = op[7:0];
            np = stack_top_entry;
            m_flush = 1'b1;
        end else if (op == OP_CONFIG) m_cfg = m_acc;
        else if (op == OP_SLEEP) begin
            {m_wdt, m_pre, m_to, m_pd, m_sleep} = {16'h0000, 3'b101};
        end else if (op[11:6] == OPF_ROTATE || op[11:6] == OPF_SUBTRACT) begin
            if (op[11:6] == OPF_ROTATE) begin
                r = {f[6:0], m_c};
                m_c = f[7];
            end else begin
                r = f - m_acc;
                m_c = f >= m_acc;
                m_dc = f[3:0] >= m_acc[3:0];
                m_z = r == 8'h00;
            end
            if (op[DEST_BIT]) begin
                m_f[op[4:0]] = r;
                {m_we, m_wa, m_wd} = {1'b1, op[4:0], r};
            end else m_acc = r;
        end
        m_pc = np;
    endtask : step

    ////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, clk_en, wdt_tick, wake_pin, stack_top_entry} = '0;
        void'($urandom(11104));
        foreach (u_mem.rom[i]) u_mem.rom[i] = rand_op();
        foreach (m_f[i]) begin
            m_f[i] = 8'($urandom);
            u_mem.regs[i] = m_f[i];
        end
        {m_pc, m_acc, m_cfg} = {9'h000, ACC_RST, CONFIG_RST};
        {m_wdt, m_pre} = 16'h0000;
        {m_c, m_dc, m_z, m_to, m_pd, m_we, m_flush, m_sleep} = 8'b00011000;
        repeat (10) @(negedge mclk);
        compare_all();
        rstn = 1'b1;
        repeat (3000) begin
            @(negedge mclk);
            compare_all();
            clk_en = $urandom_range(7) != 0;
            wdt_tick = 1'($urandom);
            stack_top_entry = 9'($urandom);
            step();
        end
        // new program and inputs go in before the model steps
        @(negedge mclk);
        compare_all();
        foreach (u_mem.rom[i]) u_mem.rom[i] = OP_SLEEP;
        {clk_en, wdt_tick} = 2'b10;
        step();
        repeat (6) begin
            @(negedge mclk);
            compare_all();
            step();
        end
        wake_pin = 1'b1;
        repeat (2) @(negedge mclk);
        chk(16'({sleeping, osc_run}), 16'h0002);
        @(negedge mclk);
        chk(16'({sleeping, osc_run}), 16'h0001);
        give_verdict();
    end
endmodule : tb_cpu_instruction_execute_subset
